// ---- verilog/exp_bus_pkg.sv ----
// Constants and types shared by the expansion bus controller files.
// Assumes a single 100 MHz clock domain and synchronous active-high reset.
package exp_bus_pkg;
	localparam int NUM_CS = 8;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int PHASE_W = 4;
	localparam int NUM_PHASES = 5;
	localparam int SIZE_W = 5;
	// Window size code: bytes = 512 << code, code 0..15 gives 512 B..16 MB
	localparam logic [SIZE_W-1:0] SIZE_CODE_MAX = 5'h0F;
	localparam int MIN_WIN_LOG2 = 9;
	localparam int DSP_CS_FIRST = 4;
	localparam int GPIO_CLK_DIV_W = 8;
	localparam logic [GPIO_CLK_DIV_W-1:0] GPIO_CLK_DIV_RST = 8'h02;
	localparam logic [ADDR_W-1:0] STRAP_RST = 24'h000000;
	localparam logic [PHASE_W-1:0] PHASE_CNT_RST = 4'h0;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_SETUP = 6'b000100,
		ST_STROBE = 6'b001000,
		ST_HOLD = 6'b010000,
		ST_RECOV = 6'b100000
	} phase_e;

	typedef enum logic [1:0] {
		STYLE_STROBE_RW = 2'h0,
		STYLE_DS_RNW = 2'h1,
		STYLE_DSP_BYTE = 2'h2,
		STYLE_DSP_HALF = 2'h3
	} style_e;
endpackage

// ---- verilog/exp_clk_div.sv ----
// Programmable clock output for general-purpose pin 15.
// Assumes divisor changes are rare; a change takes effect in the half period already under way.
`timescale 1ns/100ps
module exp_clk_div (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [exp_bus_pkg::GPIO_CLK_DIV_W-1:0] halfPeriod,
	output logic clkOut,
	output logic tick
);
	import exp_bus_pkg::*;

	logic [GPIO_CLK_DIV_W-1:0] cnt_r, cnt_nxt;
	logic clk_r, clk_nxt;
	logic [GPIO_CLK_DIV_W-1:0] limit;

	// Divisor 0 would stall; treat it as 1 so the output never stops
	assign limit = (halfPeriod == '0) ? GPIO_CLK_DIV_W'(1) : halfPeriod;

	always_comb begin
		cnt_nxt = cnt_r + GPIO_CLK_DIV_W'(1);
		clk_nxt = clk_r;
		tick = 1'b0;
		if (cnt_r >= limit - GPIO_CLK_DIV_W'(1)) begin
			cnt_nxt = '0;
			clk_nxt = ~clk_r;
			tick = ~clk_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= '0;
			clk_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			clk_r <= clk_nxt;
		end
	end

	assign clkOut = clk_r;
endmodule

// ---- verilog/exp_bus_ctrl.sv ----
// Expansion bus controller: eight chip selects, five-phase accesses, strap capture.
// Assumes the requester holds reqValid with stable fields until reqDone.
`timescale 1ns/100ps
module exp_bus_ctrl #(
	parameter int NCS = exp_bus_pkg::NUM_CS
) (
	input wire logic mclk,
	input wire logic rst,
	// Requester side
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [exp_bus_pkg::ADDR_W-1:0] reqAddr,
	input wire logic [exp_bus_pkg::DATA_W-1:0] reqWdata,
	output logic reqReady,
	output logic reqDone,
	output logic reqMiss,
	output logic [exp_bus_pkg::DATA_W-1:0] reqRdata,
	// Per-select configuration, flattened, then the clock divisor shared by all selects
	input wire logic [NCS-1:0] csEnable,
	input wire logic [NCS*exp_bus_pkg::ADDR_W-1:0] csBase,
	input wire logic [NCS*exp_bus_pkg::SIZE_W-1:0] csSize,
	input wire logic [NCS*exp_bus_pkg::NUM_PHASES*exp_bus_pkg::PHASE_W-1:0] csPhaseLen,
	input wire logic [NCS*2-1:0] csStyle,
	input wire logic [NCS-1:0] csMuxed,
	input wire logic [exp_bus_pkg::GPIO_CLK_DIV_W-1:0] clkHalfPeriod,
	// Expansion pins, then the captured strap value
	output logic [NCS-1:0] csN,
	input wire logic [exp_bus_pkg::ADDR_W-1:0] addrIn,
	output logic [exp_bus_pkg::ADDR_W-1:0] addrOut,
	output logic addrOe,
	input wire logic [exp_bus_pkg::DATA_W-1:0] dataIn,
	output logic [exp_bus_pkg::DATA_W-1:0] dataOut,
	output logic dataOe,
	output logic aleOut,
	output logic rdN,
	output logic wrN,
	output logic rnwOut,
	output logic byteHigh,
	output logic gpio15Out,
	output logic gpio15Oe,
	output logic [exp_bus_pkg::ADDR_W-1:0] strapCfg
);
	import exp_bus_pkg::*;

	// Window match for one select
	function automatic logic inWindow(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
		input logic [SIZE_W-1:0] code);
		logic [ADDR_W-1:0] mask;
		logic [SIZE_W-1:0] c;
		c = (code > SIZE_CODE_MAX) ? SIZE_CODE_MAX : code;
		mask = ~((ADDR_W'(1) << (c + SIZE_W'(MIN_WIN_LOG2))) - ADDR_W'(1));
		inWindow = ((a & mask) == (base & mask));
	endfunction

	phase_e st_r, st_nxt;
	logic [PHASE_W-1:0] cnt_r, cnt_nxt;
	logic [2:0] cs_r, cs_nxt;
	logic half_r, half_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic done_r, done_nxt;
	logic miss_r, miss_nxt;
	logic strapTaken_r, strapTaken_nxt;
	logic [ADDR_W-1:0] strap_r, strap_nxt;
	logic [NCS-1:0] hit;
	logic anyHit;
	logic [2:0] hitIdx;
	logic busTick;
	logic [PHASE_W-1:0] curLen;
	logic [1:0] curStyle;
	logic curMuxed;
	logic dspStyle;

	// Expansion timing base; also drives pin 15 as an output from reset
	exp_clk_div u_clk (
		.mclk(mclk),
		.rst(rst),
		.halfPeriod(clkHalfPeriod),
		.clkOut(gpio15Out),
		.tick(busTick)
	);
	assign gpio15Oe = 1'b1;

	// Window decode; lowest select wins an overlap
	genvar g;
	generate
		for (g = 0; g < NCS; g++) begin : g_hit
			assign hit[g] = csEnable[g] && inWindow(reqAddr, csBase[g*ADDR_W +: ADDR_W],
				csSize[g*SIZE_W +: SIZE_W]);
		end
	endgenerate

	always_comb begin
		hitIdx = '0;
		anyHit = 1'b0;
		for (int i = NCS - 1; i >= 0; i--) begin
			if (hit[i]) begin
				hitIdx = 3'(i);
				anyHit = 1'b1;
			end
		end
	end

	assign curStyle = csStyle[cs_r*2 +: 2];
	assign curMuxed = csMuxed[cs_r];
	// Host-port styles only honoured on the upper four selects
	assign dspStyle = curStyle[1] && (cs_r >= 3'(DSP_CS_FIRST));

	always_comb begin
		unique case (st_r)
			ST_ADDR: curLen = csPhaseLen[(cs_r*NUM_PHASES+0)*PHASE_W +: PHASE_W];
			ST_SETUP: curLen = csPhaseLen[(cs_r*NUM_PHASES+1)*PHASE_W +: PHASE_W];
			ST_STROBE: curLen = csPhaseLen[(cs_r*NUM_PHASES+2)*PHASE_W +: PHASE_W];
			ST_HOLD: curLen = csPhaseLen[(cs_r*NUM_PHASES+3)*PHASE_W +: PHASE_W];
			ST_RECOV: curLen = csPhaseLen[(cs_r*NUM_PHASES+4)*PHASE_W +: PHASE_W];
			default: curLen = PHASE_CNT_RST;
		endcase
	end

	// Access sequencer; each phase lasts curLen+1 bus ticks
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		cs_nxt = cs_r;
		half_nxt = half_r;
		rdata_nxt = rdata_r;
		done_nxt = 1'b0;
		miss_nxt = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (reqValid && !done_r && !miss_r) begin
					if (anyHit) begin
						st_nxt = ST_ADDR;
						cs_nxt = hitIdx;
						cnt_nxt = PHASE_CNT_RST;
						half_nxt = 1'b0;
					end else begin
						miss_nxt = 1'b1;
					end
				end
			end
			default: begin
				if (busTick) begin
					if (cnt_r >= curLen) begin
						cnt_nxt = PHASE_CNT_RST;
						unique case (st_r)
							ST_ADDR: st_nxt = ST_SETUP;
							ST_SETUP: st_nxt = ST_STROBE;
							ST_STROBE: begin
								st_nxt = ST_HOLD;
								if (!reqWrite) begin
									// Byte host-port only ever reads the low lane
									if (dspStyle && curStyle == STYLE_DSP_BYTE) begin
										if (half_r) begin
											rdata_nxt[DATA_W-1:8] = dataIn[7:0];
										end else begin
											rdata_nxt[7:0] = dataIn[7:0];
										end
									end else begin
										rdata_nxt = dataIn;
									end
								end
							end
							ST_HOLD: st_nxt = ST_RECOV;
							default: begin
								// Byte host-port moves a halfword as two byte strobes
								if (dspStyle && curStyle == STYLE_DSP_BYTE && !half_r) begin
									half_nxt = 1'b1;
									st_nxt = ST_SETUP;
								end else begin
									st_nxt = ST_IDLE;
									done_nxt = 1'b1;
									// Lane flag must not outlive the access
									half_nxt = 1'b0;
								end
							end
						endcase
					end else begin
						cnt_nxt = cnt_r + PHASE_W'(1);
					end
				end
			end
		endcase
	end

	// Strap capture on the first clock after reset release
	always_comb begin
		strapTaken_nxt = 1'b1;
		strap_nxt = strapTaken_r ? strap_r : addrIn;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= ST_IDLE;
			cnt_r <= PHASE_CNT_RST;
			cs_r <= '0;
			half_r <= 1'b0;
			rdata_r <= '0;
			done_r <= 1'b0;
			miss_r <= 1'b0;
			strapTaken_r <= 1'b0;
			strap_r <= STRAP_RST;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			cs_r <= cs_nxt;
			half_r <= half_nxt;
			rdata_r <= rdata_nxt;
			done_r <= done_nxt;
			miss_r <= miss_nxt;
			strapTaken_r <= strapTaken_nxt;
			strap_r <= strap_nxt;
		end
	end

	assign strapCfg = strap_r;
	assign reqReady = (st_r == ST_IDLE) && !done_r && !miss_r;
	assign reqDone = done_r;
	assign reqMiss = miss_r;
	assign reqRdata = rdata_r;

	// Pin drive; address bus released until straps are taken
	always_comb begin
		logic active;
		logic strobe;
		logic [DATA_W-1:0] wd;
		active = (st_r != ST_IDLE);
		strobe = (st_r == ST_STROBE);
		csN = '1;
		if (active) begin
			csN[cs_r] = 1'b0;
		end
		wd = reqWdata;
		if (dspStyle && curStyle == STYLE_DSP_BYTE) begin
			wd = {8'h00, half_r ? reqWdata[15:8] : reqWdata[7:0]};
		end
		addrOut = active ? reqAddr : '0;
		addrOe = strapTaken_r;
		byteHigh = half_r;
		aleOut = active && curMuxed && (st_r == ST_ADDR);
		// Muxed mode shares low address lines with data
		dataOut = (curMuxed && st_r == ST_ADDR) ? reqAddr[DATA_W-1:0] : wd;
		dataOe = active && ((curMuxed && st_r == ST_ADDR) || (reqWrite && st_r != ST_ADDR && st_r != ST_RECOV));
		if (curStyle == STYLE_STROBE_RW) begin
			rdN = ~(strobe && !reqWrite);
			wrN = ~(strobe && reqWrite);
			rnwOut = 1'b1;
		end else begin
			// Single data strobe plus direction line
			rdN = ~strobe;
			wrN = 1'b1;
			rnwOut = active ? !reqWrite : 1'b1;
		end
	end
endmodule

// ---- bench/exp_bus_ctrl_sva.sv ----
// Port checker for the expansion bus controller.
// Assumes one clock domain, synchronous active-high reset.
`timescale 1ns/100ps
module exp_bus_sva import exp_bus_pkg::*; #(
	parameter int NCS = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic reqDone,
	input wire logic reqMiss,
	input wire logic [NCS-1:0] csN,
	input wire logic [ADDR_W-1:0] addrIn,
	input wire logic [ADDR_W-1:0] strapCfg,
	input wire logic dataOe,
	input wire logic aleOut,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic byteHigh,
	input wire logic gpio15Oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_strap; $past(rst) |=> strapCfg == $past(addrIn); endproperty
	a_strap: assert property (p_strap) else $error("strap capture wrong");
	property p_oneCs; $countones(~csN) <= 1; endproperty
	a_oneCs: assert property (p_oneCs) else $error("two selects low");
	property p_missQuiet; reqMiss |-> &csN; endproperty
	a_missQuiet: assert property (p_missQuiet) else $error("select on miss");
	property p_pulse; (reqDone || reqMiss) |=> !(reqDone || reqMiss); endproperty
	a_pulse: assert property (p_pulse) else $error("completion not a pulse");
	property p_take; reqValid && reqReady |=> !(&csN) || reqMiss; endproperty
	a_take: assert property (p_take) else $error("no select after take");
	property p_strobes; rdN || wrN; endproperty
	a_strobes: assert property (p_strobes) else $error("both strobes low");
	property p_aleCs; aleOut |-> !(&csN); endproperty
	a_aleCs: assert property (p_aleCs) else $error("ale without select");
	property p_byteCs; byteHigh |-> $countones(~csN[NCS-1:DSP_CS_FIRST]) == 1; endproperty
	a_byteCs: assert property (p_byteCs) else $error("host-port on low select");
	property p_gpioOe; gpio15Oe; endproperty
	a_gpioOe: assert property (p_gpioOe) else $error("pin 15 not output");
	property p_rst; disable iff (1'b0) rst |=> &csN && !dataOe && rdN && wrN; endproperty
	a_rst: assert property (p_rst) else $error("pins active in reset");
	property p_strapHold; !$past(rst) && !$past(rst, 2) |-> $stable(strapCfg); endproperty
	a_strapHold: assert property (p_strapHold) else $error("strap value moved");
	c_done: cover property (reqDone);
	c_miss: cover property (reqMiss);
	c_byte: cover property (byteHigh && !rdN);
endmodule
bind exp_bus_ctrl exp_bus_sva #(.NCS(NCS)) i_sva (.mclk(mclk), .rst(rst), .reqValid(reqValid),
	.reqReady(reqReady), .reqDone(reqDone), .reqMiss(reqMiss), .csN(csN), .addrIn(addrIn),
	.strapCfg(strapCfg), .dataOe(dataOe), .aleOut(aleOut), .rdN(rdN), .wrN(wrN),
	.byteHigh(byteHigh), .gpio15Oe(gpio15Oe));

// ---- bench/exp_periph_model.sv ----
// Peripheral model: fixed read data while selected and read-strobed.
// Assumes byte host-port reads use the low lane, low byte first.
`timescale 1ns/100ps
module exp_periph_model (
	input wire logic mclk,
	input wire logic [7:0] csN,
	input wire logic rdN,
	input wire logic byteHigh,
	output logic [15:0] dataIn
);
	localparam logic [15:0] RD = 16'hC35A;
	logic flip = 1'b0;
	// Released bus toggles so a late sample cannot match
	always @(posedge mclk) flip <= ~flip;
	always_comb begin
		if (!(&csN) && !rdN) dataIn = {RD[15:8], byteHigh ? RD[15:8] : RD[7:0]};
		else dataIn = {16{flip}};
	end
endmodule

// ---- bench/exp_bus_ctrl_test.sv ----
// Bench for the expansion bus controller with a peripheral model.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/100ps
module exp_bus_ctrl_test;
	import exp_bus_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, prevG = 1'b0;
	logic reqReady, reqDone, reqMiss, addrOe, dataOe, aleOut, rdN, wrN, rnwOut, byteHigh, gpio15Out, gpio15Oe;
	logic [23:0] reqAddr = 24'h000000, addrIn = 24'h5A3C96, addrOut, strapCfg;
	logic [15:0] reqWdata = 16'h0000, reqRdata, dataIn, dataOut, csStyle = 16'h0800;
	logic [7:0] csEnable = 8'h21, csMuxed = 8'h20, csN, seenCs;
	logic [7:0] clkHalfPeriod = 8'h02;
	logic [191:0] csBase = '0;
	logic [39:0] csSize = '0;
	logic [159:0] csPhaseLen = {40{4'h1}};
	logic seenByte, seenAle, seenRnw, seenWr;
	logic [16:0] wdSeen;
	logic [23:0] adSeen;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, rises = 0, dur;
	exp_bus_ctrl i_dut (.*);
	exp_periph_model i_model (.*);
	always #5 mclk = ~mclk;
	always @(negedge mclk) begin
		cyc++;
		rises += int'(gpio15Out && !prevG);
		prevG = gpio15Out;
		seenCs = seenCs | ~csN;
		seenByte = seenByte | byteHigh;
		seenAle = seenAle | aleOut;
		// Direction line low while selected means a write cycle
		seenRnw = seenRnw | (~rnwOut & ~(&csN));
		seenWr = seenWr | ~wrN;
		if (!wrN) wdSeen = {dataOe, dataOut};
		if (!rdN || !wrN) adSeen = addrOut;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude;
		end
	end
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic access(input logic w, input logic [23:0] a);
		int n;
		n = 0;
		@(negedge mclk);
		{seenCs, seenByte, seenAle, seenRnw, seenWr} = '0;
		wdSeen = '0;
		adSeen = '0;
		check("ready idle", reqReady, 1'b1);
		reqWrite = w;
		reqAddr = a;
		reqWdata = 16'hBEEF;
		reqValid = 1'b1;
		do begin
			@(negedge mclk);
			n++;
		end while (reqDone !== 1'b1 && reqMiss !== 1'b1 && n < 3000);
		dur = n;
		// A hung access counts against the run
		if (n >= 3000) n_mismatch++;
		check("ready at end", reqReady, 1'b0);
		reqValid = 1'b0;
	endtask
	task automatic t_strap;
		int r0;
		check("strapCfg", strapCfg, 24'h5A3C96);
		check("gpio15Oe", gpio15Oe, 1'b1);
		check("addrOe", addrOe, 1'b1);
		r0 = rises;
		// Straps are taken once; later pin levels must not leak in
		addrIn = 24'hA5C369;
		repeat (40) @(negedge mclk);
		check("gpio15 rises", rises - r0, 24'd10);
		check("strap held", strapCfg, 24'h5A3C96);
	endtask
	task automatic t_cs0;
		access(1'b1, 24'h0001FE);
		check("write select", seenCs, 8'h01);
		check("write data", wdSeen, {1'b1, 16'hBEEF});
		check("write addr", adSeen, 24'h0001FE);
		check("write strobe", seenWr, 1'b1);
		check("rnw separate", seenRnw, 1'b0);
		access(1'b0, 24'h0001FE);
		check("read data", reqRdata, 16'hC35A);
		check("phase time", dur >= 36, 1'b1);
	endtask
	task automatic t_miss;
		access(1'b0, 24'h000200);
		check("miss", reqMiss, 1'b1);
		check("miss select", seenCs, 8'h00);
	endtask
	task automatic t_byte;
		access(1'b0, 24'h800FFE);
		check("byte data", reqRdata, 16'hC35A);
		check("byte high", seenByte, 1'b1);
		check("ale", seenAle, 1'b1);
		check("select 5", seenCs, 8'h20);
		check("byte time", dur >= 68, 1'b1);
	endtask
	task automatic t_phase;
		@(negedge mclk);
		csPhaseLen[19:0] = {5{4'h3}};
		csStyle[1:0] = 2'h1;
		access(1'b1, 24'h000010);
		check("rnw write", seenRnw, 1'b1);
		check("no write strobe", seenWr, 1'b0);
		access(1'b0, 24'h000010);
		check("long data", reqRdata, 16'hC35A);
		check("long time", dur >= 76, 1'b1);
		check("rnw", seenRnw, 1'b0);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		csBase[120 +: 24] = 24'h800000;
		csSize[25 +: 5] = 5'h03;
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		t_strap;
		// Byte read first, so its high byte cannot be left over from an earlier read
		t_byte;
		t_cs0;
		t_miss;
		t_phase;
		conclude;
	end
endmodule
